// ==== hw/opmode_pkg.sv ====
// package: constants for the drive operation-mode selector
// assumes: single 50 MHz clock, AHB-Lite register access
package opmode_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PFREQ  = 8'h08;
  localparam logic [7:0] OFS_NCMD   = 8'h0C;
  localparam logic [7:0] OFS_PWREQ  = 8'h10;
  localparam logic [7:0] OFS_PWSTAT = 8'h14;

  // mode-select setting values
  localparam logic [2:0] SEL_SWITCH = 3'h0;
  localparam logic [2:0] SEL_PANEL  = 3'h1;
  localparam logic [2:0] SEL_EXTFIX = 3'h2;
  localparam logic [2:0] SEL_COMB1  = 3'h3;
  localparam logic [2:0] SEL_COMB2  = 3'h4;
  localparam logic [2:0] SEL_RUNSW  = 3'h6;
  localparam logic [2:0] SEL_ILOCK  = 3'h7;

  // reset values
  localparam logic [2:0] RST_SEL    = 3'h0;
  localparam logic [1:0] RST_WSEL   = 2'h0;

  // input function code that routes the interlock
  localparam logic [7:0] FUNC_ILOCK = 8'h0C;
  localparam int         NUM_IFUNC  = 5;

  // parameter numbers used by write permission
  localparam logic [9:0] PNUM_MODE_SEL  = 10'd79;
  localparam logic [9:0] PNUM_WRITE_SEL = 10'd77;
  localparam logic [9:0] PNUM_IFUNC_LO  = 10'd178;

  // active mode
  typedef enum logic [1:0] {
    MODE_EXT,
    MODE_PANEL,
    MODE_NET
  } mode_e;

  // frequency source codes on the freq_src output
  localparam logic [2:0] FSRC_ANALOG2 = 3'h0;
  localparam logic [2:0] FSRC_ANALOG4 = 3'h1;
  localparam logic [2:0] FSRC_MSPEED  = 3'h2;
  localparam logic [2:0] FSRC_JOG     = 3'h3;
  localparam logic [2:0] FSRC_PANEL   = 3'h4;
  localparam logic [2:0] FSRC_NET     = 3'h5;
  localparam logic [2:0] FSRC_HELD    = 3'h6;

  localparam int FREQ_W = 16;

endpackage

// ==== hw/opmode_sel.sv ====
// operation-mode selector: picks run and frequency sources for the drive
// assumes: inputs synchronous to core_clk, one AHB-Lite master, OKAY only
module opmode_sel (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hsel,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        forward_start_input,
  input  wire logic        reverse_start_input,
  input  wire logic        current_input_select,
  input  wire logic        output_stop_input,
  input  wire logic [4:0]  term_in,
  input  wire logic        panel_external_toggle_key,
  input  wire logic        panel_run_fwd,
  input  wire logic        panel_run_rev,
  input  wire logic        stop_key,
  input  wire logic        mspeed_active,
  input  wire logic        jog_active,
  input  wire logic        motor_running,
  input  wire logic [15:0] analog2_freq,
  input  wire logic [15:0] analog4_freq,
  input  wire logic [15:0] mspeed_freq,
  input  wire logic [15:0] jog_freq,
  output logic      [1:0]  active_mode,
  output logic             run_fwd,
  output logic             run_rev,
  output logic      [15:0] freq_cmd,
  output logic      [2:0]  freq_src,
  output logic             output_stop
);

  // ==========================================================
  // bus slave
  // ==========================================================
  logic        ap_valid;
  logic        dp_wr_r;
  logic [7:0]  dp_addr_r;
  logic        wr_strobe;

  assign ap_valid  = hsel && hready && htrans[1];
  assign wr_strobe = dp_wr_r;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= 8'h00;
    end
    else
    begin
      dp_wr_r <= ap_valid && hwrite;
      if (ap_valid)
        dp_addr_r <= haddr[7:0];
    end
  end

  // ==========================================================
  // control registers
  // ==========================================================
  logic [2:0]  mode_sel_r;
  logic [1:0]  write_sel_r;
  logic [7:0]  ifunc_r [opmode_pkg::NUM_IFUNC];
  logic [15:0] panel_freq_r;
  logic [15:0] net_freq_r;
  logic        net_fwd_r;
  logic        net_rev_r;
  logic        net_req_net;
  logic        net_req_ext;
  logic        pw_req;
  logic [9:0]  pw_num;
  logic        pw_ok_r;
  logic        pw_done_r;
  logic        sel_write;
  logic        stopped;
  logic        ilock;
  logic        ilock_routed;
  opmode_pkg::mode_e mode_r;

  assign stopped = !motor_running;

  always_comb
  begin
    ilock_routed = 1'b0;
    ilock        = output_stop_input;
    for (int i = 0; i < opmode_pkg::NUM_IFUNC; i++)
    begin
      if (ifunc_r[i] == opmode_pkg::FUNC_ILOCK)
      begin
        ilock_routed = 1'b1;
        ilock        = term_in[i];
      end
    end
  end

  assign sel_write = wr_strobe && dp_addr_r == opmode_pkg::OFS_CTRL
                     && stopped;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      mode_sel_r  <= opmode_pkg::RST_SEL;
      write_sel_r <= opmode_pkg::RST_WSEL;
    end
    else
    begin
      if (sel_write && hwdata[2:0] != 3'h5)
        mode_sel_r <= hwdata[2:0];
      if (wr_strobe && dp_addr_r == opmode_pkg::OFS_CTRL)
        write_sel_r <= hwdata[5:4];
    end
  end

  // panel and network command registers
  assign net_req_net = wr_strobe && dp_addr_r == opmode_pkg::OFS_NCMD
                       && hwdata[24];
  assign net_req_ext = wr_strobe && dp_addr_r == opmode_pkg::OFS_NCMD
                       && hwdata[25];
  assign pw_req = wr_strobe && dp_addr_r == opmode_pkg::OFS_PWREQ;
  assign pw_num = hwdata[25:16];

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      panel_freq_r <= 16'h0000;
      net_freq_r   <= 16'h0000;
      net_fwd_r    <= 1'b0;
      net_rev_r    <= 1'b0;
    end
    else
    begin
      if (wr_strobe && dp_addr_r == opmode_pkg::OFS_PFREQ)
        panel_freq_r <= hwdata[15:0];
      if (wr_strobe && dp_addr_r == opmode_pkg::OFS_NCMD
          && mode_r == opmode_pkg::MODE_NET)
      begin
        net_freq_r <= hwdata[15:0];
        net_fwd_r  <= hwdata[16];
        net_rev_r  <= hwdata[17];
      end
    end
  end

  // parameter write gate; the request names a parameter number and value
  logic pw_allow;
  logic ext_ok;
  assign ext_ok = pw_num == opmode_pkg::PNUM_MODE_SEL
                  || pw_num == opmode_pkg::PNUM_WRITE_SEL;

  always_comb
  begin
    pw_allow = 1'b1;
    if (write_sel_r == 2'h1)
      pw_allow = pw_num == opmode_pkg::PNUM_MODE_SEL
                 || pw_num == opmode_pkg::PNUM_WRITE_SEL;
    if (write_sel_r == 2'h0 && motor_running)
      pw_allow = 1'b0;
    if (mode_r == opmode_pkg::MODE_EXT && !ext_ok)
      pw_allow = 1'b0;
    // interlock off allows mode select only
    if (mode_sel_r == opmode_pkg::SEL_ILOCK && !ilock)
      pw_allow = pw_num == opmode_pkg::PNUM_MODE_SEL;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pw_ok_r   <= 1'b0;
      pw_done_r <= 1'b0;
      for (int i = 0; i < opmode_pkg::NUM_IFUNC; i++)
        ifunc_r[i] <= 8'h00;
    end
    else if (pw_req)
    begin
      pw_done_r <= 1'b1;
      pw_ok_r   <= pw_allow;
      if (pw_allow && pw_num >= opmode_pkg::PNUM_IFUNC_LO
          && pw_num < opmode_pkg::PNUM_IFUNC_LO + 10'(opmode_pkg::NUM_IFUNC))
        ifunc_r[3'(pw_num - opmode_pkg::PNUM_IFUNC_LO)] <= hwdata[7:0];
    end
  end

  // ==========================================================
  // mode state machine
  // ==========================================================
  logic  toggle_ok;
  logic  move_ok;
  logic  boot_r;
  opmode_pkg::mode_e mode_nxt;

  // only setting 6 acts on key or link requests while running
  assign move_ok = stopped || mode_sel_r == opmode_pkg::SEL_RUNSW;
  assign toggle_ok = mode_sel_r == opmode_pkg::SEL_SWITCH
                     || mode_sel_r == opmode_pkg::SEL_RUNSW
                     || (mode_sel_r == opmode_pkg::SEL_ILOCK && ilock);

  always_comb
  begin
    mode_nxt = mode_r;
    case (mode_r)
      opmode_pkg::MODE_EXT:
      begin
        if (panel_external_toggle_key && toggle_ok && move_ok)
          mode_nxt = opmode_pkg::MODE_PANEL;
        else if (net_req_net && move_ok
                 && mode_sel_r != opmode_pkg::SEL_COMB1
                 && mode_sel_r != opmode_pkg::SEL_COMB2
                 && (mode_sel_r != opmode_pkg::SEL_ILOCK || ilock))
          mode_nxt = opmode_pkg::MODE_NET;
      end
      opmode_pkg::MODE_PANEL:
      begin
        if (panel_external_toggle_key && toggle_ok && move_ok)
          mode_nxt = opmode_pkg::MODE_EXT;
        else if (net_req_net && toggle_ok && move_ok)
          mode_nxt = opmode_pkg::MODE_NET;
      end
      opmode_pkg::MODE_NET:
      begin
        if (net_req_ext && move_ok)
          mode_nxt = opmode_pkg::MODE_EXT;
        else if (panel_external_toggle_key && toggle_ok && move_ok)
          mode_nxt = opmode_pkg::MODE_PANEL;
      end
      default: mode_nxt = opmode_pkg::MODE_EXT;
    endcase
    if (mode_sel_r == opmode_pkg::SEL_PANEL)
      mode_nxt = opmode_pkg::MODE_PANEL;
    else if (mode_sel_r == opmode_pkg::SEL_COMB1
             || mode_sel_r == opmode_pkg::SEL_COMB2)
      mode_nxt = opmode_pkg::MODE_EXT;
    else if (mode_sel_r == opmode_pkg::SEL_EXTFIX
             && mode_nxt == opmode_pkg::MODE_PANEL)
      mode_nxt = opmode_pkg::MODE_EXT;
    if (mode_sel_r == opmode_pkg::SEL_ILOCK && !ilock)
      mode_nxt = opmode_pkg::MODE_EXT;
    if (boot_r)
      mode_nxt = mode_sel_r == opmode_pkg::SEL_PANEL ?
                 opmode_pkg::MODE_PANEL : opmode_pkg::MODE_EXT;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      mode_r <= opmode_pkg::MODE_EXT;
      boot_r <= 1'b1;
    end
    else
    begin
      mode_r <= mode_nxt;
      boot_r <= 1'b0;
    end
  end

  // ==========================================================
  // carried command on switch-over
  // ==========================================================
  logic [15:0] held_freq_r;
  logic        held_fwd_r;
  logic        held_rev_r;
  logic        held_valid_r;
  logic [15:0] ext_freq;
  logic [2:0]  ext_src;
  logic [15:0] out_freq;
  logic [2:0]  out_src;
  logic        out_fwd;
  logic        out_rev;

  always_comb
  begin
    ext_freq = analog2_freq;
    ext_src  = opmode_pkg::FSRC_ANALOG2;
    if (jog_active)
    begin
      ext_freq = jog_freq;
      ext_src  = opmode_pkg::FSRC_JOG;
    end
    else if (mspeed_active)
    begin
      ext_freq = mspeed_freq;
      ext_src  = opmode_pkg::FSRC_MSPEED;
    end
    else if (current_input_select)
    begin
      ext_freq = analog4_freq;
      ext_src  = opmode_pkg::FSRC_ANALOG4;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      held_freq_r  <= 16'h0000;
      held_fwd_r   <= 1'b0;
      held_rev_r   <= 1'b0;
      held_valid_r <= 1'b0;
    end
    else if (mode_nxt != mode_r
             && mode_sel_r == opmode_pkg::SEL_RUNSW)
    begin
      held_valid_r <= mode_nxt != opmode_pkg::MODE_EXT;
      held_freq_r  <= out_freq;
      held_fwd_r   <= out_fwd;
      held_rev_r   <= out_rev;
    end
    else if (wr_strobe && ((dp_addr_r == opmode_pkg::OFS_NCMD
                            && mode_r == opmode_pkg::MODE_NET)
             || (dp_addr_r == opmode_pkg::OFS_PFREQ
                 && mode_r == opmode_pkg::MODE_PANEL)))
      held_valid_r <= 1'b0;
  end

  always_comb
  begin
    out_freq = ext_freq;
    out_src  = ext_src;
    out_fwd  = forward_start_input;
    out_rev  = reverse_start_input;
    case (mode_r)
      opmode_pkg::MODE_EXT:
      begin
        if (mode_sel_r == opmode_pkg::SEL_COMB1 && !mspeed_active
            && !current_input_select)
        begin
          out_freq = panel_freq_r;
          out_src  = opmode_pkg::FSRC_PANEL;
        end
        if (mode_sel_r == opmode_pkg::SEL_COMB2)
        begin
          out_fwd = panel_run_fwd;
          out_rev = panel_run_rev;
        end
      end
      opmode_pkg::MODE_PANEL:
      begin
        out_freq = held_valid_r ? held_freq_r : panel_freq_r;
        out_src  = held_valid_r ? opmode_pkg::FSRC_HELD
                                : opmode_pkg::FSRC_PANEL;
        out_fwd  = held_valid_r ? held_fwd_r : panel_run_fwd;
        out_rev  = held_valid_r ? held_rev_r : panel_run_rev;
      end
      opmode_pkg::MODE_NET:
      begin
        out_freq = held_valid_r ? held_freq_r : net_freq_r;
        out_src  = held_valid_r ? opmode_pkg::FSRC_HELD
                                : opmode_pkg::FSRC_NET;
        out_fwd  = held_valid_r ? held_fwd_r : net_fwd_r;
        out_rev  = held_valid_r ? held_rev_r : net_rev_r;
      end
      default: out_freq = ext_freq;
    endcase
  end

  // ==========================================================
  // registered outputs
  // ==========================================================
  logic stop_nxt;
  // output stop in external under interlock
  assign stop_nxt = stop_key
    || (mode_sel_r == opmode_pkg::SEL_ILOCK && ilock
        && mode_r == opmode_pkg::MODE_EXT)
    || (mode_sel_r != opmode_pkg::SEL_ILOCK && !ilock_routed
        && output_stop_input);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      active_mode <= 2'h0;
      run_fwd     <= 1'b0;
      run_rev     <= 1'b0;
      freq_cmd    <= 16'h0000;
      freq_src    <= opmode_pkg::FSRC_ANALOG2;
      output_stop <= 1'b0;
    end
    else
    begin
      active_mode <= mode_r;
      run_fwd     <= out_fwd && !stop_nxt;
      run_rev     <= out_rev && !stop_nxt;
      freq_cmd    <= out_freq;
      freq_src    <= out_src;
      output_stop <= stop_nxt;
    end
  end

  // ==========================================================
  // read path
  // ==========================================================
  logic [31:0] rd_nxt;
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    case (haddr[7:0])
      opmode_pkg::OFS_CTRL:   rd_nxt = {26'h0, write_sel_r, 1'b0, mode_sel_r};
      opmode_pkg::OFS_STATUS: rd_nxt = {24'h0, ilock_routed, ilock,
                                        held_valid_r, output_stop,
                                        motor_running, 1'b0, mode_r};
      opmode_pkg::OFS_PFREQ:  rd_nxt = {16'h0, panel_freq_r};
      opmode_pkg::OFS_NCMD:   rd_nxt = {14'h0, net_rev_r, net_fwd_r,
                                        net_freq_r};
      opmode_pkg::OFS_PWSTAT: rd_nxt = {30'h0, pw_ok_r, pw_done_r};
      default:                rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else if (ap_valid && !hwrite)
      hrdata <= rd_nxt;
  end

  // ==========================================================
  // checks
  // ==========================================================
  AST_FIXED_PANEL: assert property (
    @(posedge core_clk) disable iff (rst)
    mode_sel_r == opmode_pkg::SEL_PANEL && !boot_r |=>
      mode_r == opmode_pkg::MODE_PANEL)
    else $error("setting 1 left panel mode");
  AST_LOCK_EXT: assert property (
    @(posedge core_clk) disable iff (rst)
    mode_sel_r == opmode_pkg::SEL_EXTFIX |=>
      mode_r != opmode_pkg::MODE_PANEL)
    else $error("setting 2 reached panel mode");
  AST_ILOCK_OFF: assert property (
    @(posedge core_clk) disable iff (rst)
    mode_sel_r == opmode_pkg::SEL_ILOCK && !ilock |=>
      mode_r == opmode_pkg::MODE_EXT)
    else $error("interlock off did not force external");
  AST_TOGGLE: assert property (
    @(posedge core_clk) disable iff (rst)
    mode_sel_r == opmode_pkg::SEL_SWITCH && stopped && !boot_r
      && panel_external_toggle_key && mode_r == opmode_pkg::MODE_EXT |=>
      mode_r == opmode_pkg::MODE_PANEL)
    else $error("toggle did not reach panel");
  AST_STOP_KEY: assert property (
    @(posedge core_clk) disable iff (rst)
    stop_key |=> output_stop && !run_fwd && !run_rev)
    else $error("stop key not honoured");
  AST_SEL_RUN: assert property (
    @(posedge core_clk) disable iff (rst)
    motor_running |=> $stable(mode_sel_r))
    else $error("mode select changed while running");
  AST_EXT_FREQ: assert property (
    @(posedge core_clk) disable iff (rst)
    mode_r == opmode_pkg::MODE_EXT && mode_sel_r != opmode_pkg::SEL_COMB1
      && jog_active |=> freq_src == opmode_pkg::FSRC_JOG)
    else $error("jog not selected in external");
  AST_COMB1: assert property (
    @(posedge core_clk) disable iff (rst)
    mode_sel_r == opmode_pkg::SEL_COMB1 && mode_r == opmode_pkg::MODE_EXT
      && mspeed_active && !jog_active |=>
      freq_src == opmode_pkg::FSRC_MSPEED)
    else $error("multispeed lost to panel");
  AST_BOOT: assert property (@(posedge core_clk)
    $fell(rst) && mode_sel_r == opmode_pkg::SEL_SWITCH |=>
      mode_r == opmode_pkg::MODE_EXT)
    else $error("power-on mode wrong");

endmodule

// ==== testbench/opmode_far_model.sv ====
// far-side model: operator panel keys, terminal switches, analog words
// assumes: the bench calls its tasks; every change lands after a rising edge
module opmode_far_model (
  input  wire logic        core_clk,
  output logic             forward_start_input,
  output logic             reverse_start_input,
  output logic             current_input_select,
  output logic             output_stop_input,
  output logic      [4:0]  term_in,
  output logic             panel_external_toggle_key,
  output logic             panel_run_fwd,
  output logic             panel_run_rev,
  output logic             stop_key,
  output logic             mspeed_active,
  output logic             jog_active,
  output logic             motor_running,
  output logic      [15:0] analog2_freq,
  output logic      [15:0] analog4_freq,
  output logic      [15:0] mspeed_freq,
  output logic      [15:0] jog_freq
);
  timeunit 1ns;
  timeprecision 1ns;

  // no terminal routed: the stop input doubles as the interlock
  initial
  begin
    {motor_running, jog_active, mspeed_active, stop_key} = 4'h0;
    {panel_run_rev, panel_run_fwd, output_stop_input} = 3'h0;
    {current_input_select, reverse_start_input} = 2'h0;
    forward_start_input = 1'b0;
    term_in = 5'h00;
    panel_external_toggle_key = 1'b0;
    {analog2_freq, analog4_freq, mspeed_freq, jog_freq} = 64'h0;
  end

  // ==========================================================
  // panel key
  // panel/external toggle by key
  task automatic press();
    @(posedge core_clk);
    panel_external_toggle_key <= 1'b1;
    @(posedge core_clk);
    panel_external_toggle_key <= 1'b0;
  endtask

  // ==========================================================
  // switch levels and frequency words
  // terminal levels ride above the ten switch bits
  task automatic levels(input logic [14:0] v);
    @(posedge core_clk);
    {term_in, motor_running, jog_active, mspeed_active, stop_key,
     panel_run_rev, panel_run_fwd, output_stop_input,
     current_input_select, reverse_start_input,
     forward_start_input} <= v;
  endtask

  task automatic freqs(input logic [15:0] a2, input logic [15:0] a4,
                       input logic [15:0] ms, input logic [15:0] jg);
    @(posedge core_clk);
    {analog2_freq, analog4_freq, mspeed_freq, jog_freq} <= {a2, a4, ms, jg};
  endtask
endmodule

// ==== testbench/tb.sv ====
// bench: AHB-Lite register access plus far-side stimulus, self-checking
// assumes: zero-wait slave, mode change visible within three cycles
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic [31:0] haddr    = 32'h0000_0000;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [2:0]  hsize    = 3'h2;
  logic [31:0] hwdata   = 32'h0000_0000;
  logic        hsel     = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        fwd_in, rev_in, cur_sel_in, stop_in, toggle_key;
  logic        prun_fwd, prun_rev, stop_key, ms_act, jog_act, running;
  logic [4:0]  term_in;
  logic [15:0] a2_f, a4_f, ms_f, jog_f, freq_cmd;
  logic [1:0]  active_mode;
  logic        run_fwd, run_rev, output_stop;
  logic [2:0]  freq_src;
  int          miscompares = 0;
  int          checks_done = 0;

  always #10 core_clk = ~core_clk;

  opmode_far_model u_opmode_far_model (.core_clk(core_clk),
    .forward_start_input(fwd_in), .reverse_start_input(rev_in),
    .current_input_select(cur_sel_in), .output_stop_input(stop_in),
    .term_in(term_in), .panel_external_toggle_key(toggle_key),
    .panel_run_fwd(prun_fwd), .panel_run_rev(prun_rev),
    .stop_key(stop_key), .mspeed_active(ms_act), .jog_active(jog_act),
    .motor_running(running), .analog2_freq(a2_f), .analog4_freq(a4_f),
    .mspeed_freq(ms_f), .jog_freq(jog_f));

  opmode_sel u_opmode_sel (.core_clk(core_clk), .rst(rst), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .forward_start_input(fwd_in),
    .reverse_start_input(rev_in), .current_input_select(cur_sel_in),
    .output_stop_input(stop_in), .term_in(term_in),
    .panel_external_toggle_key(toggle_key), .panel_run_fwd(prun_fwd),
    .panel_run_rev(prun_rev), .stop_key(stop_key), .mspeed_active(ms_act),
    .jog_active(jog_act), .motor_running(running), .analog2_freq(a2_f),
    .analog4_freq(a4_f), .mspeed_freq(ms_f), .jog_freq(jog_f),
    .active_mode(active_mode), .run_fwd(run_fwd), .run_rev(run_rev),
    .freq_cmd(freq_cmd), .freq_src(freq_src), .output_stop(output_stop));

  // ==========================================================
  // bus cycles and comparisons
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    {hsel, htrans, hwrite, hsize} <= {1'b1, 2'h2, w, 3'h2};
    haddr <= {24'h00_0000, a};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    {hsel, htrans} <= {1'b0, 2'h0};
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_reg(input string nm, input logic [7:0] a,
                         input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(nm, exp, q);
  endtask

  // mode changes show two cycles after their cause
  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic note(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    repeat (4000) @(posedge core_clk);
    miscompares++;
    end_of_test();
  end

  // ==========================================================
  // test sequence
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    settle();
    chk("mode", opmode_pkg::MODE_EXT, active_mode);
    chk_reg("ctrl", opmode_pkg::OFS_CTRL, 32'h0000_0000);
    chk_reg("unmapped", 8'h20, 32'h0000_0000);
    chk("hresp", 32'h0, hresp);
    // input-function write refused in external mode
    wr(opmode_pkg::OFS_PWREQ, 32'h00B2_000C);
    chk_reg("pwstat", opmode_pkg::OFS_PWSTAT, 32'h0000_0001);
    note("reset");
    u_opmode_far_model.freqs(16'h1234, 16'h0A44, 16'h0444, 16'h0333);
    u_opmode_far_model.levels(10'h001);
    settle();
    chk("run_fwd", 32'h1, run_fwd);
    chk("src", opmode_pkg::FSRC_ANALOG2, freq_src);
    chk("freq", 32'h1234, freq_cmd);
    u_opmode_far_model.levels(10'h041);
    settle();
    chk("output_stop", 32'h1, output_stop);
    chk("run_fwd", 32'h0, run_fwd);
    u_opmode_far_model.levels(10'h001);
    u_opmode_far_model.press();
    settle();
    chk("mode", opmode_pkg::MODE_PANEL, active_mode);
    u_opmode_far_model.press();
    settle();
    chk("mode", opmode_pkg::MODE_EXT, active_mode);
    note("toggle");
    wr(opmode_pkg::OFS_CTRL, 32'h0000_0006);
    // motor running: only switch-over mode may move now
    u_opmode_far_model.levels(10'h201);
    // request only: the link word itself is not stored outside net mode
    wr(opmode_pkg::OFS_NCMD, 32'h0100_0000);
    settle();
    chk("mode", opmode_pkg::MODE_NET, active_mode);
    chk("src", opmode_pkg::FSRC_HELD, freq_src);
    chk("freq", 32'h1234, freq_cmd);
    chk("run_fwd", 32'h1, run_fwd);
    wr(opmode_pkg::OFS_NCMD, 32'h0001_0777);
    settle();
    chk("src", opmode_pkg::FSRC_NET, freq_src);
    chk("freq", 32'h0777, freq_cmd);
    u_opmode_far_model.freqs(16'h2222, 16'h0A44, 16'h0444, 16'h0333);
    u_opmode_far_model.levels(10'h002);
    wr(opmode_pkg::OFS_NCMD, 32'h0200_0000);
    settle();
    chk("mode", opmode_pkg::MODE_EXT, active_mode);
    chk("freq", 32'h2222, freq_cmd);
    chk("run_rev", 32'h1, run_rev);
    chk("run_fwd", 32'h0, run_fwd);
    note("switchover");
    wr(opmode_pkg::OFS_CTRL, 32'h0000_0002);
    u_opmode_far_model.press();
    settle();
    chk("mode", opmode_pkg::MODE_EXT, active_mode);
    u_opmode_far_model.levels(10'h200);
    wr(opmode_pkg::OFS_CTRL, 32'h0000_0001);
    chk_reg("ctrl", opmode_pkg::OFS_CTRL, 32'h0000_0002);
    note("locked");
    u_opmode_far_model.levels(10'h001);
    wr(opmode_pkg::OFS_CTRL, 32'h0000_0003);
    wr(opmode_pkg::OFS_PFREQ, 32'h0000_0300);
    settle();
    chk("src", opmode_pkg::FSRC_PANEL, freq_src);
    chk("freq", 32'h0300, freq_cmd);
    chk("run_fwd", 32'h1, run_fwd);
    u_opmode_far_model.levels(10'h081);
    settle();
    chk("src", opmode_pkg::FSRC_MSPEED, freq_src);
    chk("freq", 32'h0444, freq_cmd);
    u_opmode_far_model.levels(10'h005);
    settle();
    chk("src", opmode_pkg::FSRC_ANALOG4, freq_src);
    chk("freq", 32'h0A44, freq_cmd);
    u_opmode_far_model.levels(10'h010);
    wr(opmode_pkg::OFS_CTRL, 32'h0000_0004);
    settle();
    chk("run_fwd", 32'h1, run_fwd);
    chk("src", opmode_pkg::FSRC_ANALOG2, freq_src);
    u_opmode_far_model.levels(10'h120);
    settle();
    chk("src", opmode_pkg::FSRC_JOG, freq_src);
    chk("run_rev", 32'h1, run_rev);
    note("combined");
    u_opmode_far_model.levels(10'h000);
    wr(opmode_pkg::OFS_CTRL, 32'h0000_0007);
    settle();
    chk("mode", opmode_pkg::MODE_EXT, active_mode);
    u_opmode_far_model.levels(10'h008);
    settle();
    chk("output_stop", 32'h1, output_stop);
    u_opmode_far_model.press();
    settle();
    chk("mode", opmode_pkg::MODE_PANEL, active_mode);
    u_opmode_far_model.levels(10'h000);
    settle();
    chk("mode", opmode_pkg::MODE_EXT, active_mode);
    wr(opmode_pkg::OFS_NCMD, 32'h0100_0000);
    u_opmode_far_model.press();
    settle();
    chk("mode", opmode_pkg::MODE_EXT, active_mode);
    // route the interlock to terminal 0, which is still off
    u_opmode_far_model.levels(15'h0008);
    u_opmode_far_model.press();
    wr(opmode_pkg::OFS_PWREQ, 32'h00B2_000C);
    settle();
    chk("mode", opmode_pkg::MODE_EXT, active_mode);
    chk_reg("pwstat", opmode_pkg::OFS_PWSTAT, 32'h0000_0003);
    u_opmode_far_model.levels(15'h0400);
    settle();
    chk("output_stop", 32'h1, output_stop);
    note("interlock");
    end_of_test();
  end
endmodule
